// ---- pkg/pir_params.svh ----
`ifndef PIR_PARAMS_SVH
`define PIR_PARAMS_SVH

// ----------------------------------------------------------------
// parameter block word offsets
// ----------------------------------------------------------------
`define PIR_W_CODE      5'h00
`define PIR_W_OPTS      5'h01
`define PIR_W_STATUS    5'h02
`define PIR_W_VECT      5'h04
`define PIR_W_LEVEL     5'h05
`define PIR_W_PRN       5'h0e
`define PIR_W_LAST      5'h15

// ----------------------------------------------------------------
// command codes and field positions
// ----------------------------------------------------------------
`define PIR_CMD_PRN_INIT 16'h004a
`define PIR_CMD_RESTART  16'h004b
`define PIR_OPT_IE       0
`define PIR_PRN_BUF      13
`define PIR_PRN_ODD      14
`define PIR_PRN_RST      15
`define PIR_OPTS_KEEP    16'h0001
`define PIR_LEVEL_KEEP   16'h0007
`define PIR_PRN_KEEP     16'he0ff
`define PIR_MASK_PARITY  4'hf
`define PIR_MASK_STROBE  4'h7

// ----------------------------------------------------------------
// return status values
// ----------------------------------------------------------------
`define PIR_ST_OK        16'h0000
`define PIR_ST_BAD_CMD   16'h0001
`define PIR_ST_BAD_LEVEL 16'h0002
`define PIR_ST_BAD_QUEUE 16'h0003

// ----------------------------------------------------------------
// host register map
// ----------------------------------------------------------------
`define PIR_R_CTRL      6'h20
`define PIR_R_STAT      6'h21
`define PIR_R_RET       6'h22
`define PIR_R_IRQ       6'h23
`define PIR_CTRL_GO     15

`endif

// ---- pkg/pir_pkg.sv ----
package pir_pkg;
	typedef logic [15:0] pir_word_t;
	typedef logic [4:0]  pir_idx_t;
	typedef enum {
		PIR_IDLE, PIR_DECODE, PIR_PRN, PIR_RS_SCSI, PIR_RS_FLUSH, PIR_RS_REWIND, PIR_POST
	} pir_state_t;
endpackage : pir_pkg

// ---- pkg/pir_if.sv ----
`timescale 1ns/100ps
interface pir_if;
	import pir_pkg::*;
	logic       wordWr;
	pir_idx_t   wordIdx;
	pir_word_t  wordData;
	logic       submit;
	logic [7:0] queueNum;
	logic       masterEntry;
	logic       busy;
	logic       done;
	pir_word_t  retStatus;
	logic       irqReq;
	logic [2:0] irqLevel;
	logic [7:0] irqVector;
	logic       irqAck;

	modport dev (
		input  wordWr, wordIdx, wordData, submit, queueNum, masterEntry, irqAck,
		output busy, done, retStatus, irqReq, irqLevel, irqVector
	);
	modport host (
		output wordWr, wordIdx, wordData, submit, queueNum, masterEntry, irqAck,
		input  busy, done, retStatus, irqReq, irqLevel, irqVector
	);
endinterface : pir_if

// ---- hw/pir_dev.sv ----
// Behaviour
// - code 0x4A decodes as printer port init
// - options bit 0 gates completion interrupt
// - host zeroes all reserved bits
// - error vector low byte, normal high
// - level bits 0-2; zero only without interrupt
// - enable bits gate status-change interrupts
// - parity type: cable, parity, online, ready
// - strobe type: paper empty, select, fault
// - status lines are active high
// - bit 13 asserts flush or init line
// - line held until init with bit clear
// - bit 14 parity odd, parity type only
// - bit 15 resets the printer port
// - print accepted after init status returned
// - 16-bit return status, zero is success
// - code 0x4B decodes as soft restart
// - restart order: scsi, flush, rewind, post
// - restart keeps init parameters and queue mode
// - restart only via master entry, queue 0
// - host may request sense after restart
// - status vector from init block word 2
// - printer queue first gets init command
`timescale 1ns/100ps
`include "pir_params.svh"
module pir_dev #(
	parameter int LINES = 4
) (
	input  wire logic             clk,
	input  wire logic             rst,
	pir_if.dev                    link,
	input  wire logic             prnParityType,
	input  wire logic [LINES-1:0] prnLines,
	input  wire logic [7:0]       ctrlInitWord2,
	input  wire logic             queueModeIn,
	input  wire logic             statusAck,
	output logic [LINES-1:0]      prnStatus,
	output logic                  statusIrq,
	output logic [7:0]            statusVector,
	output logic                  bufFlushOrInit,
	output logic                  parityOdd,
	output logic                  prnPortRst,
	output logic                  printReady,
	output logic                  scsiPortRst,
	output logic                  flushPending,
	output logic                  queuePtrRewind,
	output logic                  queueModeActive
);
	import pir_pkg::*;

	pir_word_t         pb [0:21];
	pir_state_t        state;
	pir_word_t         status;
	logic [LINES-1:0]  sync1;
	logic [LINES-1:0]  sync2;
	logic [LINES-1:0]  sync3;
	logic [LINES-1:0]  stable;
	logic [LINES-1:0]  statusEnable;
	logic [LINES-1:0]  changed;
	logic [LINES-1:0]  typeMask;
	logic [7:0]        subQueue;
	logic              subMaster;
	logic              ieBit;

	assign ieBit    = pb[`PIR_W_OPTS][`PIR_OPT_IE];
	assign typeMask = prnParityType ? LINES'(`PIR_MASK_PARITY)
	                                : LINES'(`PIR_MASK_STROBE);

	// ----------------------------------------------------------------
	// parameter block store
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (link.wordWr && state == PIR_IDLE && link.wordIdx <= `PIR_W_LAST) begin
			pb[link.wordIdx] <= link.wordData;
		end else if (state == PIR_POST) begin
			pb[`PIR_W_STATUS] <= status;
		end
	end

	// ----------------------------------------------------------------
	// command sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state     <= PIR_IDLE;
			status    <= `PIR_ST_OK;
			subQueue  <= 8'h00;
			subMaster <= 1'b0;
		end else begin
			unique case (state)
				PIR_IDLE: begin
					if (link.submit) begin
						subQueue  <= link.queueNum;
						subMaster <= link.masterEntry;
						state     <= PIR_DECODE;
					end
				end
				PIR_DECODE: begin
					state <= PIR_POST;
					if (ieBit && pb[`PIR_W_LEVEL][2:0] == 3'h0) begin
						status <= `PIR_ST_BAD_LEVEL;
					end else if (pb[`PIR_W_CODE] == `PIR_CMD_PRN_INIT) begin
						status <= `PIR_ST_OK;
						state  <= PIR_PRN;
					end else if (pb[`PIR_W_CODE] == `PIR_CMD_RESTART) begin
						if (subMaster && subQueue == 8'h00) begin
							status <= `PIR_ST_OK;
							state  <= PIR_RS_SCSI;
						end else begin
							status <= `PIR_ST_BAD_QUEUE;
						end
					end else begin
						status <= `PIR_ST_BAD_CMD;
					end
				end
				PIR_PRN:       state <= PIR_POST;
				PIR_RS_SCSI:   state <= PIR_RS_FLUSH;
				PIR_RS_FLUSH:  state <= PIR_RS_REWIND;
				PIR_RS_REWIND: state <= PIR_POST;
				PIR_POST:      state <= PIR_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// restart strobes, one per step so the order is visible outside
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			scsiPortRst    <= 1'b0;
			flushPending   <= 1'b0;
			queuePtrRewind <= 1'b0;
		end else begin
			scsiPortRst    <= state == PIR_RS_SCSI;
			flushPending   <= state == PIR_RS_FLUSH;
			queuePtrRewind <= state == PIR_RS_REWIND;
		end
	end

	// queue mode follows its source only; a restart never touches it
	always_ff @(posedge clk) begin
		if (rst) begin
			queueModeActive <= 1'b0;
		end else begin
			queueModeActive <= queueModeIn;
		end
	end

	// ----------------------------------------------------------------
	// printer port configuration
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			statusEnable   <= '0;
			bufFlushOrInit <= 1'b0;
			parityOdd      <= 1'b0;
			prnPortRst     <= 1'b0;
			printReady     <= 1'b1;
		end else begin
			prnPortRst <= 1'b0;
			if (state == PIR_PRN) begin
				statusEnable   <= pb[`PIR_W_PRN][LINES-1:0] & typeMask;
				bufFlushOrInit <= pb[`PIR_W_PRN][`PIR_PRN_BUF];
				if (prnParityType) begin
					parityOdd <= pb[`PIR_W_PRN][`PIR_PRN_ODD];
				end
				if (pb[`PIR_W_PRN][`PIR_PRN_RST]) begin
					prnPortRst <= 1'b1;
					printReady <= 1'b0;
				end
			end else if (state == PIR_POST) begin
				printReady <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// status line synchroniser and change detect
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1  <= '0;
			sync2  <= '0;
			sync3  <= '0;
			stable <= '0;
		end else begin
			sync1 <= prnLines;
			sync2 <= sync1;
			sync3 <= sync2;
			if (sync2 == sync3) begin
				stable <= sync3;
			end
		end
	end

	assign changed = (sync2 == sync3) ? (sync3 ^ stable) & statusEnable : '0;

	always_ff @(posedge clk) begin
		if (rst) begin
			prnStatus    <= '0;
			statusIrq    <= 1'b0;
			statusVector <= 8'h00;
		end else begin
			prnStatus    <= stable;
			statusVector <= ctrlInitWord2;
			if (|changed) begin
				statusIrq <= 1'b1;
			end else if (statusAck) begin
				statusIrq <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// completion answer and interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			link.busy      <= 1'b0;
			link.done      <= 1'b0;
			link.retStatus <= `PIR_ST_OK;
			link.irqReq    <= 1'b0;
			link.irqLevel  <= 3'h0;
			link.irqVector <= 8'h00;
		end else begin
			link.busy <= (state != PIR_IDLE && state != PIR_POST) || link.submit;
			link.done <= state == PIR_POST;
			if (state == PIR_POST) begin
				link.retStatus <= status;
			end
			if (state == PIR_POST && ieBit) begin
				link.irqReq   <= 1'b1;
				link.irqLevel <= pb[`PIR_W_LEVEL][2:0];
				link.irqVector <= (status == `PIR_ST_OK) ? pb[`PIR_W_VECT][15:8]
				                                        : pb[`PIR_W_VECT][7:0];
			end else if (link.irqAck) begin
				link.irqReq <= 1'b0;
			end
		end
	end
endmodule : pir_dev

// ---- hw/pir_host.sv ----
`timescale 1ns/100ps
`include "pir_params.svh"
module pir_host (
	input  wire logic             clk,
	input  wire logic             rst,
	pir_if.host                   link,
	input  wire logic [5:0]       addr,
	input  wire pir_pkg::pir_word_t wrData,
	input  wire logic             wrStb,
	input  wire logic             rdStb,
	output pir_pkg::pir_word_t    rdData
);
	import pir_pkg::*;

	pir_word_t  masked;
	pir_word_t  retHeld;
	logic       doneFlag;
	logic       restartSeen;
	logic       codeRestart;

	// reserved bits are cleared on the way out so a sloppy driver cannot leak them
	always_comb begin
		masked = wrData;
		if (addr[4:0] == `PIR_W_OPTS) begin
			masked = wrData & `PIR_OPTS_KEEP;
		end else if (addr[4:0] == `PIR_W_LEVEL) begin
			masked = wrData & `PIR_LEVEL_KEEP;
		end else if (addr[4:0] == `PIR_W_PRN) begin
			masked = wrData & `PIR_PRN_KEEP;
		end
	end

	// ----------------------------------------------------------------
	// link drive
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			link.wordWr      <= 1'b0;
			link.wordIdx     <= 5'h00;
			link.wordData    <= 16'h0000;
			link.submit      <= 1'b0;
			link.queueNum    <= 8'h00;
			link.masterEntry <= 1'b0;
			link.irqAck      <= 1'b0;
			codeRestart      <= 1'b0;
		end else begin
			link.wordWr <= wrStb && addr < 6'h16 && !link.busy;
			link.submit <= 1'b0;
			link.irqAck <= wrStb && addr == `PIR_R_IRQ;
			if (wrStb && addr < 6'h16) begin
				link.wordIdx  <= addr[4:0];
				link.wordData <= masked;
				if (addr[4:0] == `PIR_W_CODE) begin
					codeRestart <= wrData == `PIR_CMD_RESTART;
				end
			end
			if (wrStb && addr == `PIR_R_CTRL && wrData[`PIR_CTRL_GO] && !link.busy) begin
				link.submit <= 1'b1;
				if (codeRestart) begin
					link.queueNum    <= 8'h00;
					link.masterEntry <= 1'b1;
				end else begin
					link.queueNum    <= wrData[7:0];
					link.masterEntry <= wrData[8];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// completion capture
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			retHeld     <= 16'h0000;
			doneFlag    <= 1'b0;
			restartSeen <= 1'b0;
		end else begin
			if (link.done) begin
				retHeld     <= link.retStatus;
				doneFlag    <= 1'b1;
				restartSeen <= codeRestart && link.retStatus == `PIR_ST_OK;
			end else if (rdStb && addr == `PIR_R_STAT) begin
				doneFlag <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			rdData <= 16'h0000;
		end else if (rdStb) begin
			unique case (addr)
				`PIR_R_STAT: rdData <= {13'h0, restartSeen, doneFlag, link.busy};
				`PIR_R_RET:  rdData <= retHeld;
				`PIR_R_IRQ:  rdData <= {4'h0, link.irqReq, link.irqLevel, link.irqVector};
				default:     rdData <= 16'h0000;
			endcase
		end
	end
endmodule : pir_host

// ---- bench/pir_checker.sv ----
`timescale 1ns/100ps
`include "pir_params.svh"
module pir_checker (
	input wire logic               clk,
	input wire logic               rst,
	input wire logic               wordWr,
	input wire pir_pkg::pir_idx_t  wordIdx,
	input wire pir_pkg::pir_word_t wordData,
	input wire logic               submit,
	input wire logic               busy,
	input wire logic               done,
	input wire pir_pkg::pir_word_t retStatus,
	input wire logic               irqReq,
	input wire logic [2:0]         irqLevel,
	input wire logic [7:0]         irqVector,
	input wire logic               irqAck
);
	import pir_pkg::*;
	// ----------------------------------------
	// shadow of the block words the device takes
	// ----------------------------------------
	pir_word_t code;
	pir_word_t opts;
	pir_word_t vect;
	pir_word_t lvl;
	logic      ieOk;
	always_ff @(posedge clk) begin
		if (rst) begin
			code <= 16'h0000;
			opts <= 16'h0000;
			vect <= 16'h0000;
			lvl  <= 16'h0000;
		end else if (wordWr && !busy) begin
			if (wordIdx == `PIR_W_CODE) code <= wordData;
			if (wordIdx == `PIR_W_OPTS) opts <= wordData;
			if (wordIdx == `PIR_W_VECT) vect <= wordData;
			if (wordIdx == `PIR_W_LEVEL) lvl <= wordData;
		end
	end
	assign ieOk = !(opts[0] && lvl[2:0] == 3'h0);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_answer; submit && !busy |-> ##[1:8] done; endproperty
	a_answer: assert property (p_answer) else $error("no completion");
	property p_pulse; done |=> !done; endproperty
	a_pulse: assert property (p_pulse) else $error("done too long");
	property p_prn; done && code == `PIR_CMD_PRN_INIT && ieOk |-> retStatus == 16'h0000; endproperty
	a_prn: assert property (p_prn) else $error("printer init failed");
	property p_rs; done && code == `PIR_CMD_RESTART && ieOk |-> retStatus == 16'h0000; endproperty
	a_rs: assert property (p_rs) else $error("restart failed");
	property p_lvl0; done && !ieOk |-> retStatus != 16'h0000; endproperty
	a_lvl0: assert property (p_lvl0) else $error("level zero accepted");
	property p_irqOn; done && opts[0] && ieOk |-> irqReq; endproperty
	a_irqOn: assert property (p_irqOn) else $error("missing interrupt");
	property p_irqSrc; $rose(irqReq) |-> done && opts[0]; endproperty
	a_irqSrc: assert property (p_irqSrc) else $error("stray interrupt");
	property p_level; $rose(irqReq) |-> irqLevel == lvl[2:0]; endproperty
	a_level: assert property (p_level) else $error("wrong level");
	property p_vec;
		$rose(irqReq) |-> irqVector == (retStatus == 16'h0000 ? vect[15:8] : vect[7:0]);
	endproperty
	a_vec: assert property (p_vec) else $error("wrong vector");
	property p_hold; irqReq && !irqAck |=> irqReq; endproperty
	a_hold: assert property (p_hold) else $error("interrupt dropped");
endmodule : pir_checker

// ---- bench/tb_printer_init_restart_cmd_exec.sv ----
`timescale 1ns/100ps
`include "pir_params.svh"
module tb_printer_init_restart_cmd_exec;
	import pir_pkg::*;
	logic       clk     = 1'b0;
	logic       rst     = 1'b1;
	logic [5:0] addr    = 6'h00;
	pir_word_t  wrData  = 16'h0000;
	logic       wrStb   = 1'b0;
	logic       rdStb   = 1'b0;
	logic       parType = 1'b1;
	logic [3:0] lines   = 4'h0;
	logic [7:0] initVec = 8'h5c;
	logic       qMode   = 1'b1;
	logic       sAck    = 1'b0;
	pir_word_t  rdData;
	logic [3:0] prnStat;
	logic [7:0] sVec;
	logic       sIrq, bufInit, parOdd, prnRst, printRdy, scsiRst, flushP, rewind, qAct;
	int         errTotal = 0;
	int         nChecks  = 0;
	int         cyc      = 0;
	int         tScsi, tFlush, tRew;
	logic       sawRst, sawLow;
	pir_if link();
	pir_dev pir_dev_inst (.clk(clk), .rst(rst), .link(link), .prnParityType(parType),
		.prnLines(lines), .ctrlInitWord2(initVec), .queueModeIn(qMode), .statusAck(sAck),
		.prnStatus(prnStat), .statusIrq(sIrq), .statusVector(sVec), .bufFlushOrInit(bufInit),
		.parityOdd(parOdd), .prnPortRst(prnRst), .printReady(printRdy), .scsiPortRst(scsiRst),
		.flushPending(flushP), .queuePtrRewind(rewind), .queueModeActive(qAct));
	pir_host pir_host_inst (.clk(clk), .rst(rst), .link(link), .addr(addr), .wrData(wrData),
		.wrStb(wrStb), .rdStb(rdStb), .rdData(rdData));
	pir_checker pir_checker_inst (.clk(clk), .rst(rst), .wordWr(link.wordWr),
		.wordIdx(link.wordIdx), .wordData(link.wordData), .submit(link.submit),
		.busy(link.busy), .done(link.done), .retStatus(link.retStatus), .irqReq(link.irqReq),
		.irqLevel(link.irqLevel), .irqVector(link.irqVector), .irqAck(link.irqAck));
	always #2.5 clk = ~clk;
	// ----------------------------------------
	// event log: first cycle of each restart step
	// ----------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (scsiRst === 1'b1 && tScsi == 0) tScsi = cyc;
		if (flushP === 1'b1 && tFlush == 0) tFlush = cyc;
		if (rewind === 1'b1 && tRew == 0) tRew = cyc;
		if (prnRst === 1'b1) sawRst = 1'b1;
		if (printRdy === 1'b0) sawLow = 1'b1;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic testDone;
		$display("checks %0d errors %0d", nChecks, errTotal);
		if (errTotal == 0 && nChecks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : testDone
	task automatic chk(input logic ok, input string m);
		nChecks++;
		if (ok !== 1'b1) begin
			errTotal++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input pir_word_t d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
	endtask : wr
	task automatic rd(input logic [5:0] a, input pir_word_t e);
		@(posedge clk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		#1;
		chk(rdData === e, "read data");
	endtask : rd
	// queue 1 is the printer's own work queue; restart is steered to queue 0 by the host
	task automatic cmd(input pir_word_t c, o, v, l, p, st, input logic irq);
		wr(6'h00, c);
		wr(6'h01, o);
		wr(6'h04, v);
		wr(6'h05, l);
		wr(6'h0e, p);
		#1;
		tScsi = 0;
		tFlush = 0;
		tRew = 0;
		sawRst = 1'b0;
		sawLow = 1'b0;
		wr(`PIR_R_CTRL, 16'h8001);
		repeat (40) begin
			@(posedge clk);
			#1;
			if (link.done === 1'b1) break;
		end
		chk(link.done === 1'b1 && link.retStatus === st, "status");
		if (irq) chk(link.irqReq === 1'b1 && link.irqLevel === l[2:0] && link.irqVector ===
			(st === 16'h0000 ? v[15:8] : v[7:0]), "interrupt");
		else if (l[2:0] != 3'h0) chk(link.irqReq === 1'b0, "interrupt");
		wr(`PIR_R_IRQ, 16'h0000);
	endtask : cmd
	// the line synchroniser plus change detect needs a few cycles before the flag shows
	task automatic lineTest(input logic [3:0] m, input logic e);
		@(posedge clk);
		lines <= lines ^ m;
		repeat (12) @(posedge clk);
		#1;
		chk(prnStat === lines && sIrq === e && (!e || sVec === initVec), "status line");
		@(posedge clk);
		sAck <= 1'b1;
		@(posedge clk);
		sAck <= 1'b0;
	endtask : lineTest
	// the host must strip reserved bits before they reach the block
	task automatic reservedMask;
		wr(6'h01, 16'hffff);
		#1;
		chk(link.wordData === 16'h0001, "reserved option bits");
		wr(6'h05, 16'hfffd);
		#1;
		chk(link.wordData === 16'h0005, "reserved level bits");
		wr(6'h0e, 16'hffff);
		#1;
		chk(link.wordData === 16'he0ff, "reserved printer bits");
	endtask : reservedMask
	task automatic parityInit;
		cmd(16'h004a, 16'h0001, 16'h8a12, 16'h0005, 16'h600f, 16'h0000, 1'b1);
		chk(bufInit === 1'b1 && parOdd === 1'b1 && printRdy === 1'b1, "config");
		rd(`PIR_R_RET, 16'h0000);
		rd(6'h3f, 16'h0000);
		lineTest(4'h8, 1'b1);
		chk(bufInit === 1'b1, "flush line held");
	endtask : parityInit
	task automatic portReset;
		cmd(16'h004a, 16'h0000, 16'h8a12, 16'h0003, 16'h8001, 16'h0000, 1'b0);
		chk(sawRst && sawLow && printRdy === 1'b1, "port reset");
		chk(bufInit === 1'b0 && parOdd === 1'b0, "flush released");
		lineTest(4'h8, 1'b0);
	endtask : portReset
	task automatic strobeInit;
		@(posedge clk);
		parType <= 1'b0;
		cmd(16'h004a, 16'h0000, 16'h8a12, 16'h0003, 16'h600f, 16'h0000, 1'b0);
		chk(parOdd === 1'b0 && bufInit === 1'b1, "strobe config");
		lineTest(4'h8, 1'b0);
		lineTest(4'h1, 1'b1);
	endtask : strobeInit
	task automatic badCommands;
		cmd(16'h0049, 16'h0001, 16'h3377, 16'h0002, 16'h0000, 16'h0001, 1'b1);
		cmd(16'h004a, 16'h0001, 16'h3377, 16'h0000, 16'h0000, 16'h0002, 1'b0);
	endtask : badCommands
	task automatic softRestart;
		cmd(16'h004b, 16'h0001, 16'hc01e, 16'h0007, 16'h0000, 16'h0000, 1'b1);
		chk(tScsi > 0 && tScsi < tFlush && tFlush < tRew, "restart order");
		chk(qAct === 1'b1 && bufInit === 1'b1, "restart keeps mode");
		rd(`PIR_R_STAT, 16'h0006);
		rd(`PIR_R_STAT, 16'h0004);
		rd(`PIR_R_IRQ, 16'h07c0);
		@(posedge clk);
		qMode <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(qAct === 1'b0, "queue mode source");
	endtask : softRestart
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		#25000;
		errTotal++;
		testDone();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		reservedMask();
		parityInit();
		portReset();
		strobeInit();
		badCommands();
		softRestart();
		testDone();
	end
endmodule : tb_printer_init_restart_cmd_exec
